// [core/dff_fetch.v]
// How it works
// - burst 64 bytes AHB, 128 bytes AXI
// - burst crossing 1 KB becomes singles
// - unaligned line lengths drift into splits
// - line length active data, pitch steps lines
// - only window bytes fetched per line
// - programmable line interrupt position
// - vblank mode reloads settings in vsync
// - status register shows vsync active
// - vsync ends frame, buffers may flip
// - no requests raised in blanking, accepted bursts may finish there
// - addresses increase sequentially within line
//
// Chosen here: the register offsets and strobed register access.
`timescale 1ns/1ps
`default_nettype none
`include "dff_fetch_defs.vh"
module dff_fetch
(
  input wire clk_in,
  input wire resetn_in,
  input wire [3:0] reg_addr_in,
  input wire [31:0] reg_wdata_in,
  input wire reg_wr_in,
  input wire reg_rd_in,
  output reg [31:0] reg_rdata_out,
  output reg mst_req_out,
  output reg [31:0] mst_addr_out,
  output reg [7:0] mst_beats_out,
  input wire mst_ack_in,
  input wire [31:0] mst_rdata_in,
  input wire mst_rvalid_in,
  output reg [31:0] pix_data_out,
  output reg pix_valid_out,
  output reg vsync_out,
  output reg irq_out
);
  localparam ST_IDLE = 2'd0;
  localparam ST_REQ = 2'd1;
  localparam ST_DATA = 2'd2;

  // chunk length limited by what is left in the line
  function [15:0] dff_min;
    input [15:0] a;
    input [15:0] b;
    begin
      dff_min = (a < b) ? a : b;
    end
  endfunction

  // ==========================================================
  // software-visible settings
  reg [2:0] ctrl_q;
  reg [31:0] fb_sh_q, fb_act_q;
  reg [15:0] len_sh_q, len_act_q;
  reg [15:0] pitch_sh_q, pitch_act_q;
  reg [15:0] ofs_sh_q, ofs_act_q;
  reg [15:0] line_irq_q;
  reg [31:0] htim_q, vtim_q;
  reg [15:0] vsw_q;
  reg pend_q;
  reg [`DFF_IRQ_NUM-1:0] irq_st_q, irq_mask_q, irq_ev;
  wire [15:0] hcnt, vcnt;
  wire wr_layer;
  wire vsync_now, vsync_start, line_start, in_active, reload;

  dff_timing u_timing
  (
    .clk_in(clk_in),
    .resetn_in(resetn_in),
    .run_in(ctrl_q[`DFF_CTRL_EN]),
    .htot_in(htim_q[31:16]),
    .vtot_in(vtim_q[31:16]),
    .hcnt_out(hcnt),
    .vcnt_out(vcnt)
  );

  // ==========================================================
  // raster decode
  // vsync closes the frame: lines vtot-vsw .. vtot-1
  assign vsync_now = ctrl_q[`DFF_CTRL_EN] &&
    (vcnt >= vtim_q[31:16] - vsw_q);
  assign vsync_start = vsync_now && (hcnt == 16'h0000) &&
    (vcnt == vtim_q[31:16] - vsw_q);
  assign line_start = ctrl_q[`DFF_CTRL_EN] && (hcnt == 16'h0000);
  assign in_active = ctrl_q[`DFF_CTRL_EN] && (hcnt < htim_q[15:0]) &&
    (vcnt < vtim_q[15:0]);
  assign wr_layer = reg_wr_in && ((reg_addr_in == `DFF_REG_FB_ADDR) ||
    (reg_addr_in == `DFF_REG_LINE_LEN) || (reg_addr_in == `DFF_REG_PITCH) ||
    (reg_addr_in == `DFF_REG_WIN_OFS));
  // immediate mode copies at once, vblank mode waits for vsync
  assign reload = pend_q && (!ctrl_q[`DFF_CTRL_VBL] || vsync_start);

  // ==========================================================
  // register writes and shadow pending flag
  always @(posedge clk_in)
  begin
    if (!resetn_in)
    begin
      ctrl_q <= `DFF_RST_CTRL;
      fb_sh_q <= 32'h0000_0000;
      len_sh_q <= 16'h0000;
      pitch_sh_q <= 16'h0000;
      ofs_sh_q <= 16'h0000;
      line_irq_q <= 16'h0000;
      htim_q <= `DFF_RST_HTIM;
      vtim_q <= `DFF_RST_VTIM;
      vsw_q <= `DFF_RST_VSW;
      irq_mask_q <= {`DFF_IRQ_NUM{1'b0}};
      pend_q <= 1'b0;
    end
    else
    begin
      if (reg_wr_in)
      begin
        case (reg_addr_in)
          `DFF_REG_CTRL: ctrl_q <= reg_wdata_in[2:0];
          `DFF_REG_FB_ADDR: fb_sh_q <= reg_wdata_in;
          `DFF_REG_LINE_LEN: len_sh_q <= reg_wdata_in[15:0];
          `DFF_REG_PITCH: pitch_sh_q <= reg_wdata_in[15:0];
          `DFF_REG_WIN_OFS: ofs_sh_q <= reg_wdata_in[15:0];
          `DFF_REG_LINE_IRQ: line_irq_q <= reg_wdata_in[15:0];
          `DFF_REG_IRQ_MASK: irq_mask_q <= reg_wdata_in[`DFF_IRQ_NUM-1:0];
          `DFF_REG_HTIM: htim_q <= reg_wdata_in;
          `DFF_REG_VTIM: vtim_q <= reg_wdata_in;
          `DFF_REG_VSW: vsw_q <= reg_wdata_in[15:0];
          default: ;
        endcase
      end
      // a fresh write keeps the request pending over the reload
      if (wr_layer)
        pend_q <= 1'b1;
      else if (reload)
        pend_q <= 1'b0;
    end
  end

  // active copies of the layer settings
  always @(posedge clk_in)
  begin
    if (!resetn_in)
    begin
      fb_act_q <= 32'h0000_0000;
      len_act_q <= 16'h0000;
      pitch_act_q <= 16'h0000;
      ofs_act_q <= 16'h0000;
    end
    else if (reload)
    begin
      fb_act_q <= fb_sh_q;
      len_act_q <= len_sh_q;
      pitch_act_q <= pitch_sh_q;
      ofs_act_q <= ofs_sh_q;
    end
  end

  // ==========================================================
  // interrupt events, sticky status cleared by reading it
  always @*
  begin
    irq_ev = {`DFF_IRQ_NUM{1'b0}};
    irq_ev[`DFF_IRQ_LINE] = line_start && (vcnt == line_irq_q);
    irq_ev[`DFF_IRQ_VSYNC] = vsync_start;
    irq_ev[`DFF_IRQ_RELOAD] = reload;
  end

  genvar gi;
  generate
    for (gi = 0; gi < `DFF_IRQ_NUM; gi = gi + 1)
    begin : g_irq
      // set wins over a read-clear in the same cycle
      always @(posedge clk_in)
      begin
        if (!resetn_in)
          irq_st_q[gi] <= 1'b0;
        else if (irq_ev[gi])
          irq_st_q[gi] <= 1'b1;
        else if (reg_rd_in && (reg_addr_in == `DFF_REG_IRQ_STAT))
          irq_st_q[gi] <= 1'b0;
      end
    end
  endgenerate

  // ==========================================================
  // read data one cycle after the strobe, plus level outputs
  always @(posedge clk_in)
  begin
    if (!resetn_in)
    begin
      reg_rdata_out <= 32'h0000_0000;
      irq_out <= 1'b0;
      vsync_out <= 1'b0;
    end
    else
    begin
      irq_out <= |(irq_st_q & irq_mask_q);
      vsync_out <= vsync_now;
      reg_rdata_out <= 32'h0000_0000;
      if (reg_rd_in)
      begin
        case (reg_addr_in)
          `DFF_REG_CTRL: reg_rdata_out <= {29'h0, ctrl_q};
          `DFF_REG_FB_ADDR: reg_rdata_out <= fb_sh_q;
          `DFF_REG_LINE_LEN: reg_rdata_out <= {16'h0000, len_sh_q};
          `DFF_REG_PITCH: reg_rdata_out <= {16'h0000, pitch_sh_q};
          `DFF_REG_WIN_OFS: reg_rdata_out <= {16'h0000, ofs_sh_q};
          `DFF_REG_LINE_IRQ: reg_rdata_out <= {16'h0000, line_irq_q};
          `DFF_REG_STATUS: reg_rdata_out <= {29'h0, pend_q, in_active,
            vsync_now};
          `DFF_REG_IRQ_STAT: reg_rdata_out <= {29'h0, irq_st_q};
          `DFF_REG_IRQ_MASK: reg_rdata_out <= {29'h0, irq_mask_q};
          `DFF_REG_HTIM: reg_rdata_out <= htim_q;
          `DFF_REG_VTIM: reg_rdata_out <= vtim_q;
          `DFF_REG_VSW: reg_rdata_out <= {16'h0000, vsw_q};
          default: reg_rdata_out <= 32'h0000_0000;
        endcase
      end
    end
  end

  // ==========================================================
  // fetch engine
  reg [1:0] state_q;
  reg [31:0] line_base_q, addr_q;
  reg [15:0] remain_q, chunk_q;
  reg [7:0] beats_left_q;
  wire [15:0] burst_bytes, chunk;
  wire [10:0] end_in_kb;
  wire crosses;

  assign burst_bytes = ctrl_q[`DFF_CTRL_AXI] ? `DFF_BURST_AXI :
    `DFF_BURST_AHB;
  assign chunk = dff_min(burst_bytes, remain_q);
  // end of the candidate burst measured inside its 1 KB page
  assign end_in_kb = {1'b0, addr_q[9:0]} + chunk[10:0];
  assign crosses = end_in_kb > `DFF_BOUNDARY;

  always @(posedge clk_in)
  begin
    if (!resetn_in)
    begin
      state_q <= ST_IDLE;
      line_base_q <= 32'h0000_0000;
      addr_q <= 32'h0000_0000;
      remain_q <= 16'h0000;
      chunk_q <= 16'h0000;
      beats_left_q <= 8'h00;
      mst_req_out <= 1'b0;
      mst_addr_out <= 32'h0000_0000;
      mst_beats_out <= 8'h00;
      pix_data_out <= 32'h0000_0000;
      pix_valid_out <= 1'b0;
    end
    else
    begin
      pix_valid_out <= 1'b0;
      // a new active line found with the engine idle restarts the walk at its window start
      if (state_q == ST_IDLE && line_start && vcnt < vtim_q[15:0])
      begin
        if (vcnt == 16'h0000)
        begin
          line_base_q <= fb_act_q;
          addr_q <= fb_act_q + {16'h0000, ofs_act_q};
        end
        else
        begin
          line_base_q <= line_base_q + {16'h0000, pitch_act_q};
          addr_q <= line_base_q + {16'h0000, pitch_act_q} +
            {16'h0000, ofs_act_q};
        end
        remain_q <= len_act_q;
        if (len_act_q != 16'h0000)
          state_q <= ST_REQ;
      end
      else
      begin
        case (state_q)
          ST_IDLE: ;
          ST_REQ:
          begin
            // an accepted request is honoured even as the region ends
            if (mst_req_out && mst_ack_in)
            begin
              mst_req_out <= 1'b0;
              beats_left_q <= mst_beats_out;
              state_q <= ST_DATA;
            end
            else if (!in_active)
            begin
              mst_req_out <= 1'b0;
              state_q <= ST_IDLE;
            end
            else if (!mst_req_out)
            begin
              mst_req_out <= 1'b1;
              mst_addr_out <= addr_q;
              if (crosses)
              begin
                chunk_q <= `DFF_WORD_BYTES;
                mst_beats_out <= 8'h01;
              end
              else
              begin
                chunk_q <= chunk;
                mst_beats_out <= chunk[9:2];
              end
            end
          end
          ST_DATA:
          begin
            if (mst_rvalid_in)
            begin
              pix_data_out <= mst_rdata_in;
              pix_valid_out <= 1'b1;
              beats_left_q <= beats_left_q - 8'h01;
              if (beats_left_q == 8'h01)
              begin
                addr_q <= addr_q + {16'h0000, chunk_q};
                remain_q <= remain_q - chunk_q;
                if (remain_q == chunk_q)
                  state_q <= ST_IDLE;
                else
                  state_q <= ST_REQ;
              end
            end
          end
          default: state_q <= ST_IDLE;
        endcase
      end
    end
  end
endmodule // dff_fetch
`default_nettype wire

// [inc/dff_fetch_defs.vh]
`ifndef DFF_FETCH_DEFS_VH
`define DFF_FETCH_DEFS_VH
// ==========================================================
// register indices on the plain register port
`define DFF_REG_CTRL 4'h0
`define DFF_REG_FB_ADDR 4'h1
`define DFF_REG_LINE_LEN 4'h2
`define DFF_REG_PITCH 4'h3
`define DFF_REG_WIN_OFS 4'h4
`define DFF_REG_LINE_IRQ 4'h5
`define DFF_REG_STATUS 4'h6
`define DFF_REG_IRQ_STAT 4'h7
`define DFF_REG_IRQ_MASK 4'h8
`define DFF_REG_HTIM 4'h9
`define DFF_REG_VTIM 4'hA
`define DFF_REG_VSW 4'hB
// ==========================================================
// control fields
`define DFF_CTRL_EN 0
`define DFF_CTRL_AXI 1
`define DFF_CTRL_VBL 2
// status fields
`define DFF_ST_VSYNC 0
`define DFF_ST_ACTIVE 1
`define DFF_ST_PEND 2
// interrupt status fields
`define DFF_IRQ_LINE 0
`define DFF_IRQ_VSYNC 1
`define DFF_IRQ_RELOAD 2
`define DFF_IRQ_NUM 3
// ==========================================================
// reset values
`define DFF_RST_CTRL 3'h0
`define DFF_RST_HTIM 32'h0064_0050
`define DFF_RST_VTIM 32'h0014_0010
`define DFF_RST_VSW 16'h0002
// ==========================================================
// burst geometry in bytes
`define DFF_BURST_AHB 16'h0040
`define DFF_BURST_AXI 16'h0080
`define DFF_BOUNDARY 11'h400
`define DFF_WORD_BYTES 16'h0004
`endif

// [core/dff_timing.v]
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// raster counters: pixel position within line, line within frame
module dff_timing
(
  input wire clk_in,
  input wire resetn_in,
  input wire run_in,
  input wire [15:0] htot_in,
  input wire [15:0] vtot_in,
  output reg [15:0] hcnt_out,
  output reg [15:0] vcnt_out
);
  // free-running raster scan while enabled
  always @(posedge clk_in)
  begin
    if (!resetn_in || !run_in)
    begin
      hcnt_out <= 16'h0000;
      vcnt_out <= 16'h0000;
    end
    else if (hcnt_out >= htot_in - 16'h0001)
    begin
      hcnt_out <= 16'h0000;
      if (vcnt_out >= vtot_in - 16'h0001)
        vcnt_out <= 16'h0000;
      else
        vcnt_out <= vcnt_out + 16'h0001;
    end
    else
      hcnt_out <= hcnt_out + 16'h0001;
  end
endmodule // dff_timing
`default_nettype wire

// [verification/dff_fetch_props.sv]
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// port checker for the fetch block
module dff_fetch_props
(
  input wire logic clk_in,
  input wire logic resetn_in,
  input wire logic reg_rd_in,
  input wire logic [31:0] reg_rdata_out,
  input wire logic mst_req_out,
  input wire logic [31:0] mst_addr_out,
  input wire logic [7:0] mst_beats_out,
  input wire logic mst_ack_in,
  input wire logic [31:0] mst_rdata_in,
  input wire logic mst_rvalid_in,
  input wire logic [31:0] pix_data_out,
  input wire logic pix_valid_out,
  input wire logic vsync_out
);
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!resetn_in);
  // request qualifiers hold while waiting for the memory side
  a_req_hold: assert property (mst_req_out && !mst_ack_in ##1 mst_req_out
    |-> $stable(mst_addr_out) && $stable(mst_beats_out))
    else $error("request changed before ack");
  a_req_drop: assert property (
    mst_req_out && mst_ack_in |=> !mst_req_out)
    else $error("request not dropped after ack");
  a_burst_size: assert property (
    mst_req_out |-> mst_beats_out inside {[1:32]})
    else $error("burst length out of range");
  a_no_cross: assert property (mst_req_out && mst_beats_out > 8'h01
    |-> {22'h00_0000, mst_addr_out[9:0]} + {22'h00_0000, mst_beats_out, 2'h0}
    <= 32'h0000_0400)
    else $error("burst crosses page");
  a_word_align: assert property (
    mst_req_out |-> mst_addr_out[1:0] == 2'h0)
    else $error("unaligned fetch address");
  a_blank_idle: assert property (vsync_out |-> !mst_req_out)
    else $error("fetch during blanking");
  a_pix_data: assert property (mst_rvalid_in |=> pix_valid_out
    && pix_data_out == $past(mst_rdata_in))
    else $error("pixel word lost");
  a_pix_cause: assert property (pix_valid_out |-> $past(mst_rvalid_in))
    else $error("pixel without beat");
  a_rd_idle: assert property (
    !$past(reg_rd_in) |-> reg_rdata_out == 32'h0000_0000)
    else $error("read data outside slot");
  a_vsync_len: assert property ($rose(vsync_out) |-> vsync_out[*8])
    else $error("vsync too short");
endmodule // dff_fetch_props
bind dff_fetch dff_fetch_props i_dff_fetch_props (.clk_in, .resetn_in,
  .reg_rd_in, .reg_rdata_out, .mst_req_out, .mst_addr_out, .mst_beats_out,
  .mst_ack_in, .mst_rdata_in, .mst_rvalid_in, .pix_data_out, .pix_valid_out,
  .vsync_out);
`default_nettype wire

// [verification/dff_mem_model.sv]
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// memory side: accepts one request, returns address as data
module dff_mem_model
(
  input wire logic clk_in,
  input wire logic stall_in,
  input wire logic req_in,
  input wire logic [31:0] addr_in,
  input wire logic [7:0] beats_in,
  output logic ack_out,
  output logic [31:0] rdata_out,
  output logic rvalid_out
);
  logic [31:0] addr_q = 32'h0000_0000;
  logic [7:0] left_q = 8'h00;
  // stall delays both the ack and single beats
  assign ack_out = req_in && left_q == 8'h00 && !stall_in;
  assign rvalid_out = left_q != 8'h00 && !stall_in;
  assign rdata_out = rvalid_out ? addr_q : ~addr_q;
  // burst bookkeeping, consecutive words
  always @(posedge clk_in)
  begin
    if (ack_out)
    begin
      addr_q <= addr_in;
      left_q <= beats_in;
    end
    else if (rvalid_out)
    begin
      addr_q <= addr_q + 32'h0000_0004;
      left_q <= left_q - 8'h01;
    end
  end
endmodule // dff_mem_model
`default_nettype wire

// [verification/test_dff_fetch.sv]
`timescale 1ns/1ps
`default_nettype none
`include "dff_fetch_defs.vh"
module test_dff_fetch;
  localparam logic [31:0] M = 32'hFFFF_FFFF;
  localparam logic [31:0] LEN = 32'h0000_00C8;
  localparam logic [31:0] PAD = 32'h0000_0038; // padding added to the line length to form the pitch
  localparam logic [31:0] FB_A = 32'h0000_03C0;
  localparam logic [31:0] FB_B = 32'h0000_1F80;
  logic clk_in = 1'b0;
  logic resetn_in = 1'b0;
  logic [3:0] reg_addr_in = 4'h0;
  logic [31:0] reg_wdata_in = 32'h0000_0000;
  logic reg_wr_in = 1'b0;
  logic reg_rd_in = 1'b0;
  logic stall = 1'b0;
  logic rd_q = 1'b0;
  logic [7:0] seed = 8'h25;
  logic [63:0] g;
  logic [39:0] rq[$];
  logic [31:0] pq[$];
  logic [63:0] gq[$];
  int fails = 0;
  int checks = 0;
  wire [31:0] reg_rdata_out, mst_addr_out, mst_rdata_in, pix_data_out;
  wire [7:0] mst_beats_out;
  wire mst_req_out, mst_ack_in, mst_rvalid_in, pix_valid_out, vsync_out;
  wire irq_out;
  // ==========================================================
  // design and memory side
  dff_fetch i_dff_fetch
  (
    .clk_in(clk_in), .resetn_in(resetn_in), .reg_addr_in(reg_addr_in),
    .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in),
    .reg_rd_in(reg_rd_in), .reg_rdata_out(reg_rdata_out),
    .mst_req_out(mst_req_out), .mst_addr_out(mst_addr_out),
    .mst_beats_out(mst_beats_out), .mst_ack_in(mst_ack_in),
    .mst_rdata_in(mst_rdata_in), .mst_rvalid_in(mst_rvalid_in),
    .pix_data_out(pix_data_out), .pix_valid_out(pix_valid_out),
    .vsync_out(vsync_out), .irq_out(irq_out)
  );
  dff_mem_model i_dff_mem_model
  (
    .clk_in(clk_in), .stall_in(stall), .req_in(mst_req_out),
    .addr_in(mst_addr_out), .beats_in(mst_beats_out),
    .ack_out(mst_ack_in), .rdata_out(mst_rdata_in),
    .rvalid_out(mst_rvalid_in)
  );
  // clock
  initial
  begin
    forever #5 clk_in = ~clk_in;
  end
  function automatic [7:0] lfsr(input [7:0] s);
    lfsr = {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction
  task automatic chk(input [63:0] got, input [63:0] exp);
    checks++;
    if (got !== exp)
    begin
      fails++;
      $display("wrong value at %0t: %h expected %h", $time, got, exp);
    end
  endtask
  task automatic finish_test;
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  // ==========================================================
  // register port cycles
  task automatic wr(input [3:0] a, input [31:0] d);
    reg_addr_in <= a;
    reg_wdata_in <= d;
    reg_wr_in <= 1'b1;
    reg_rd_in <= 1'b0;
    @(posedge clk_in);
  endtask
  task automatic rd(input [3:0] a, input [31:0] e, input [31:0] m);
    gq.push_back({m, e});
    reg_addr_in <= a;
    reg_rd_in <= 1'b1;
    reg_wr_in <= 1'b0;
    @(posedge clk_in);
  endtask
  task automatic idle(input int n);
    reg_rd_in <= 1'b0;
    reg_wr_in <= 1'b0;
    repeat (n) @(posedge clk_in);
  endtask
  task automatic wait_v(input logic v);
    int i;
    for (i = 0; i < 9000 && vsync_out !== v; i++) @(posedge clk_in);
  endtask
  // expected requests and words of one frame, padded pitch, window at 8
  task automatic frame(input [31:0] fb, input [31:0] bst);
    logic [31:0] a, n, rem;
    for (int l = 0; l < 16; l++)
    begin
      a = fb + l * (LEN + PAD) + 8;
      rem = LEN;
      while (rem != 0)
      begin
        n = (rem < bst) ? rem : bst;
        if ((a & 32'h0000_03FF) + n > 32'h0000_0400) n = 32'h0000_0004;
        rq.push_back({n[9:2], a});
        for (int k = 0; k < n; k += 4) pq.push_back(a + k);
        a += n;
        rem -= n;
      end
    end
  endtask
  // result monitor and random stall source
  always @(posedge clk_in)
  begin
    stall <= &seed[1:0];
    seed <= lfsr(seed);
    rd_q <= reg_rd_in;
    if (rd_q)
    begin
      g = gq.pop_front();
      chk(reg_rdata_out & g[63:32], g[31:0]);
    end
    if (mst_req_out && mst_ack_in)
      chk({mst_beats_out, mst_addr_out}, rq.pop_front());
    if (pix_valid_out) chk(pix_data_out, pq.pop_front());
  end
  // main sequence
  initial
  begin
    repeat (12) @(posedge clk_in);
    resetn_in <= 1'b1;
    @(posedge clk_in);
    rd(`DFF_REG_CTRL, 32'h0000_0000, M);
    rd(`DFF_REG_HTIM, `DFF_RST_HTIM, M);
    rd(`DFF_REG_VTIM, `DFF_RST_VTIM, M);
    rd(`DFF_REG_VSW, {16'h0000, `DFF_RST_VSW}, M);
    rd(`DFF_REG_IRQ_STAT, 32'h0000_0000, M);
    rd(4'hC, 32'h0000_0000, M);
    wr(`DFF_REG_HTIM, 32'h0190_012C);
    wr(`DFF_REG_FB_ADDR, FB_A);
    wr(`DFF_REG_LINE_LEN, LEN);
    wr(`DFF_REG_PITCH, LEN + PAD);
    wr(`DFF_REG_WIN_OFS, 32'h0000_0008);
    wr(`DFF_REG_LINE_IRQ, 32'h0000_000F);
    wr(`DFF_REG_IRQ_MASK, 32'h0000_0001);
    rd(`DFF_REG_PITCH, LEN + PAD, M);
    rd(`DFF_REG_IRQ_MASK, 32'h0000_0001, M);
    frame(FB_A, 32'h0000_0040);
    frame(FB_B, 32'h0000_0080);
    wr(`DFF_REG_CTRL, 32'h0000_0001);
    idle(4);
    wr(`DFF_REG_CTRL, 32'h0000_0005);
    wr(`DFF_REG_FB_ADDR, FB_B);
    rd(`DFF_REG_STATUS, 32'h0000_0004, 32'h0000_0004);
    rd(`DFF_REG_FB_ADDR, FB_B, M);
    idle(1);
    wait_v(1'b1);
    idle(2);
    chk(irq_out, 1'b1);
    rd(`DFF_REG_IRQ_STAT, 32'h0000_0001, 32'h0000_0001);
    rd(`DFF_REG_STATUS, 32'h0000_0001, 32'h0000_0005);
    wr(`DFF_REG_CTRL, 32'h0000_0007);
    rd(`DFF_REG_IRQ_STAT, 32'h0000_0000, 32'h0000_0001);
    idle(4);
    chk(irq_out, 1'b0);
    wait_v(1'b0);
    wait_v(1'b1);
    chk(vsync_out, 1'b1);
    idle(10);
    wr(`DFF_REG_CTRL, 32'h0000_0000);
    idle(20);
    chk(pq.size(), 0);
    chk(rq.size(), 0);
    finish_test;
  end
  // watchdog
  initial
  begin
    repeat (40000) @(posedge clk_in);
    fails++;
    finish_test;
  end
endmodule // test_dff_fetch
`default_nettype wire
